// File: core/stm_seq_top.sv
// Operation
// - user level: occurrence count with else branch
// - first seen state counted n times
// - pattern seen n times, any spacing
// - pattern seen n consecutive samples
// - pattern two directly after pattern one
// - pattern three restarts sequence dependent macro
// - final pattern two with three restarts
// - too few states between two patterns
// - too many states between two patterns
// - serial bit pattern on one channel
// - pattern two too soon after one
// - pattern two too late after one
// - wait n qualified target states
// - macros on pattern terms work in state and compare mode; any, serial and delay ignore compare mode
// - primary branch wins over else branch
// - else branch clears the occurrence counter
`timescale 1ns/100ps
`default_nettype none

module stm_seq_top
    import stm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [31:0] sample_data,
    input wire logic sample_valid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic trig_out,
    output logic irq
);
    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    logic aw_free_q, w_free_q, ar_free_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_go;
    logic [31:0] ctrl_q, time_q, ser_q, ref_q;
    logic [15:0] count_q;
    logic [31:0] pval_q [3];
    logic [31:0] pmsk_q [3];
    logic [1:0] ev_sts_q, ev_msk_q;
    logic irq_q;
    logic arm_pulse;
    logic [1:0] ev_set;

    assign wr_go = !aw_free_q && !w_free_q && !bvalid_q;
    assign arm_pulse = wr_go && awaddr_q == STM_REG_CTRL && wstrb_q[0]
        && wdata_q[STM_CTRL_ARM];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            aw_free_q <= 1'b1;
            w_free_q <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= STM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && aw_free_q)
            begin
                aw_free_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && w_free_q)
            begin
                w_free_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q > STM_REG_P3_MSK || awaddr_q[1:0] != 2'h0)
                    ? STM_RESP_SLVERR : STM_RESP_OKAY;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                aw_free_q <= 1'b1;
                w_free_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q <= STM_CTRL_RST;
            count_q <= STM_COUNT_RST;
            time_q <= STM_TIME_RST;
            ser_q <= STM_ZERO_RST;
            ref_q <= STM_ZERO_RST;
            ev_msk_q <= 2'h0;
            for (int i = 0; i < 3; i++)
            begin
                pval_q[i] <= STM_ZERO_RST;
                pmsk_q[i] <= STM_ZERO_RST;
            end
        end
        else if (wr_go)
        begin
            unique case (awaddr_q)
                STM_REG_CTRL: ctrl_q <= stm_wmerge(ctrl_q, wdata_q, wstrb_q);
                STM_REG_IRQ_MSK: ev_msk_q <=
                    2'(stm_wmerge({30'h0, ev_msk_q}, wdata_q, wstrb_q));
                STM_REG_COUNT: count_q <=
                    16'(stm_wmerge({16'h0, count_q}, wdata_q, wstrb_q));
                STM_REG_TIME: time_q <= stm_wmerge(time_q, wdata_q, wstrb_q);
                STM_REG_SERIAL: ser_q <= stm_wmerge(ser_q, wdata_q, wstrb_q);
                STM_REG_CMP_REF: ref_q <= stm_wmerge(ref_q, wdata_q, wstrb_q);
                STM_REG_P1_VAL: pval_q[0] <=
                    stm_wmerge(pval_q[0], wdata_q, wstrb_q);
                STM_REG_P1_MSK: pmsk_q[0] <=
                    stm_wmerge(pmsk_q[0], wdata_q, wstrb_q);
                STM_REG_P2_VAL: pval_q[1] <=
                    stm_wmerge(pval_q[1], wdata_q, wstrb_q);
                STM_REG_P2_MSK: pmsk_q[1] <=
                    stm_wmerge(pmsk_q[1], wdata_q, wstrb_q);
                STM_REG_P3_VAL: pval_q[2] <=
                    stm_wmerge(pval_q[2], wdata_q, wstrb_q);
                STM_REG_P3_MSK: pmsk_q[2] <=
                    stm_wmerge(pmsk_q[2], wdata_q, wstrb_q);
                default: ;
            endcase
        end
    end

    // Sticky events: a set in the same cycle as a clear wins.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ev_sts_q <= 2'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (wr_go && awaddr_q == STM_REG_IRQ_STS && wstrb_q[0])
            begin
                ev_sts_q <= (ev_sts_q & ~wdata_q[1:0]) | ev_set;
            end
            else
            begin
                ev_sts_q <= ev_sts_q | ev_set;
            end
            irq_q <= |(ev_sts_q & ev_msk_q);
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    stm_state_t st_q;
    logic [4:0] lvl_q;
    logic [15:0] cnt_q, cnt_inc;
    logic [31:0] tmr_q, first_q;
    logic trig_q;
    logic [3:0] mac, arm_mac;
    logic [4:0] ser_len;
    logic ser_bit, pat_bit;
    logic m1, m2, m3;
    logic reject;
    stm_term_if term ();

    assign mac = ctrl_q[STM_CTRL_MAC_LO +: 4];
    assign ser_len = ser_q[STM_SER_LEN_LO +: 5];
    assign ser_bit = sample_data[ser_q[STM_SER_CH_LO +: 5]];
    assign pat_bit = ser_q[STM_SER_PAT_LO + lvl_q[3:0]];
    assign term.data = sample_data;
    assign term.cmp_ref = ref_q;
    assign term.cmp_mode = ctrl_q[STM_CTRL_CMP];
    assign term.val = pval_q;
    assign term.msk = pmsk_q;
    assign m1 = term.hit[0];
    assign m2 = term.hit[1];
    assign m3 = term.hit[2];
    assign cnt_inc = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h0001;
    // Arming checks the macro being written, not the one it replaces.
    assign arm_mac = wdata_q[STM_CTRL_MAC_LO +: 4];
    assign reject = stm_levels_needed(arm_mac, ser_len) > STM_LEVELS;
    assign ev_set = {arm_pulse && reject, st_q == ST_RUN && trig_q};

    stm_term_match u_match (
        .t(term.match)
    );

    // Gap timer for the time violation macros, counted in ref_clk cycles.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || lvl_q == 5'h00)
        begin
            tmr_q <= 32'h0000_0000;
        end
        else if (tmr_q != 32'hffff_ffff)
        begin
            tmr_q <= tmr_q + 32'h0000_0001;
        end
    end

    // Levels change only on a qualified sample or an arm; they rise one step at most.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_q <= ST_IDLE;
            lvl_q <= 5'h00;
            cnt_q <= 16'h0000;
            first_q <= 32'h0000_0000;
            trig_q <= 1'b0;
        end
        else if (arm_pulse)
        begin
            st_q <= reject ? ST_IDLE : ST_RUN;
            lvl_q <= 5'h00;
            cnt_q <= 16'h0000;
            trig_q <= 1'b0;
        end
        else if (st_q == ST_RUN && sample_valid && !trig_q)
        begin
            unique case (mac)
                MAC_USER:
                begin
                    if (m1)
                    begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc >= count_q) trig_q <= 1'b1;
                    end
                    else if (m2)
                    begin
                        cnt_q <= 16'h0000;
                    end
                end
                MAC_ANY:
                begin
                    if (lvl_q == 5'h00)
                    begin
                        first_q <= sample_data;
                        lvl_q <= 5'h01;
                        cnt_q <= 16'h0001;
                        if (count_q <= 16'h0001) trig_q <= 1'b1;
                    end
                    else if (sample_data == first_q)
                    begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc >= count_q) trig_q <= 1'b1;
                    end
                end
                MAC_EVENT, MAC_CONSEC:
                begin
                    if (m1)
                    begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc >= count_q) trig_q <= 1'b1;
                    end
                    else if (mac == MAC_CONSEC)
                    begin
                        cnt_q <= 16'h0000;
                    end
                end
                MAC_ADJ:
                begin
                    if (lvl_q == 5'h01 && m2) trig_q <= 1'b1;
                    else lvl_q <= {4'h0, m1};
                end
                MAC_SEQ:
                begin
                    if (m3)
                    begin
                        lvl_q <= 5'h00;
                        cnt_q <= 16'h0000;
                    end
                    else if (lvl_q == 5'h00)
                    begin
                        if (m1) lvl_q <= 5'h01;
                    end
                    else if (m2)
                    begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc >= count_q) trig_q <= 1'b1;
                    end
                end
                MAC_FEW, MAC_MANY:
                begin
                    if (lvl_q == 5'h00)
                    begin
                        if (m1) lvl_q <= 5'h01;
                        cnt_q <= 16'h0000;
                    end
                    else if (m2 && (mac == MAC_FEW) == (cnt_q < count_q))
                    begin
                        trig_q <= 1'b1;
                    end
                    else if (m2 && mac == MAC_FEW)
                    begin
                        lvl_q <= 5'h00;
                    end
                    else
                    begin
                        cnt_q <= cnt_inc;
                    end
                end
                MAC_SERIAL:
                begin
                    if (ser_bit == pat_bit)
                    begin
                        lvl_q <= lvl_q + 5'h01;
                        if (lvl_q + 5'h01 >= ser_len) trig_q <= 1'b1;
                    end
                    else
                    begin
                        lvl_q <= {4'h0, ser_bit == ser_q[STM_SER_PAT_LO]};
                    end
                end
                MAC_SOON, MAC_LATE:
                begin
                    if (lvl_q == 5'h00)
                    begin
                        if (m1) lvl_q <= 5'h01;
                    end
                    else if (m2)
                    begin
                        if ((mac == MAC_SOON) == (tmr_q < time_q))
                        begin
                            trig_q <= 1'b1;
                        end
                        else
                        begin
                            lvl_q <= 5'h00;
                        end
                    end
                end
                MAC_DELAY:
                begin
                    cnt_q <= cnt_inc;
                    if (cnt_inc >= count_q) trig_q <= 1'b1;
                end
                default: ;
            endcase
        end
        else if (trig_q)
        begin
            st_q <= ST_DONE;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ar_free_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= STM_RESP_OKAY;
        end
        else if (rvalid_q)
        begin
            if (s_axi_rready)
            begin
                rvalid_q <= 1'b0;
                ar_free_q <= 1'b1;
            end
        end
        else if (s_axi_arvalid && ar_free_q)
        begin
            ar_free_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= STM_RESP_OKAY;
            unique case (s_axi_araddr)
                STM_REG_CTRL: rdata_q <= ctrl_q & 32'hffff_fffe;
                STM_REG_STAT: rdata_q <= {19'h0, lvl_q, 5'h0,
                    trig_q, st_q};
                STM_REG_IRQ_STS: rdata_q <= {30'h0, ev_sts_q};
                STM_REG_IRQ_MSK: rdata_q <= {30'h0, ev_msk_q};
                STM_REG_COUNT: rdata_q <= {16'h0, count_q};
                STM_REG_TIME: rdata_q <= time_q;
                STM_REG_SERIAL: rdata_q <= ser_q;
                STM_REG_CMP_REF: rdata_q <= ref_q;
                STM_REG_P1_VAL: rdata_q <= pval_q[0];
                STM_REG_P1_MSK: rdata_q <= pmsk_q[0];
                STM_REG_P2_VAL: rdata_q <= pval_q[1];
                STM_REG_P2_MSK: rdata_q <= pmsk_q[1];
                STM_REG_P3_VAL: rdata_q <= pval_q[2];
                STM_REG_P3_MSK: rdata_q <= pmsk_q[2];
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= STM_RESP_SLVERR;
                end
            endcase
        end
    end

    assign s_axi_awready = aw_free_q;
    assign s_axi_wready = w_free_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ar_free_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign trig_out = trig_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic run_smp;
    assign run_smp = st_q == ST_RUN && sample_valid && !arm_pulse && !trig_q;

    a_reject_stays_idle: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        arm_pulse && reject |=> st_q == ST_IDLE && !trig_q)
        else $error("arm accepted with too many levels");
    a_primary_wins: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        run_smp && mac == MAC_USER && m1 && m2 && cnt_inc >= count_q
        |=> trig_out)
        else $error("else branch beat primary branch");
    a_else_clears: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        run_smp && mac == MAC_USER && !m1 && m2 |=> cnt_q == 16'h0000)
        else $error("else branch left count");
    a_seq_restart: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        run_smp && mac == MAC_SEQ && m3 |=> lvl_q == 5'h00 && !trig_q)
        else $error("pattern three did not restart");
    a_idle_no_step: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !sample_valid && !arm_pulse |=> $stable(lvl_q) && $stable(cnt_q))
        else $error("level moved without a sample");
    a_adj_fires: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        run_smp && mac == MAC_ADJ && lvl_q == 5'h01 && m2 |=> trig_out)
        else $error("adjacent pair missed");
    a_consec_break: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        run_smp && mac == MAC_CONSEC && !m1 |=> cnt_q == 16'h0000)
        else $error("consecutive count survived a miss");
    a_delay_count: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        run_smp && mac == MAC_DELAY && cnt_inc >= count_q |=> trig_out)
        else $error("delay did not expire");
    a_irq_follows: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ev_sts_q[STM_EV_REJECT] && ev_msk_q[STM_EV_REJECT] |=> irq)
        else $error("masked-in event raised no interrupt");
endmodule

`default_nettype wire

// File: core/stm_pkg.sv
package stm_pkg;

    localparam int unsigned STM_DW = 32;
    localparam int unsigned STM_AW = 8;

    // Register byte offsets.
    localparam logic [7:0] STM_REG_CTRL = 8'h00;
    localparam logic [7:0] STM_REG_STAT = 8'h04;
    localparam logic [7:0] STM_REG_IRQ_STS = 8'h08;
    localparam logic [7:0] STM_REG_IRQ_MSK = 8'h0c;
    localparam logic [7:0] STM_REG_COUNT = 8'h10;
    localparam logic [7:0] STM_REG_TIME = 8'h14;
    localparam logic [7:0] STM_REG_SERIAL = 8'h18;
    localparam logic [7:0] STM_REG_CMP_REF = 8'h1c;
    localparam logic [7:0] STM_REG_P1_VAL = 8'h20;
    localparam logic [7:0] STM_REG_P1_MSK = 8'h24;
    localparam logic [7:0] STM_REG_P2_VAL = 8'h28;
    localparam logic [7:0] STM_REG_P2_MSK = 8'h2c;
    localparam logic [7:0] STM_REG_P3_VAL = 8'h30;
    localparam logic [7:0] STM_REG_P3_MSK = 8'h34;

    // Control and status field positions.
    localparam int unsigned STM_CTRL_ARM = 0;
    localparam int unsigned STM_CTRL_CMP = 1;
    localparam int unsigned STM_CTRL_MAC_LO = 4;
    localparam int unsigned STM_SER_CH_LO = 0;
    localparam int unsigned STM_SER_LEN_LO = 8;
    localparam int unsigned STM_SER_PAT_LO = 16;
    localparam int unsigned STM_EV_TRIG = 0;
    localparam int unsigned STM_EV_REJECT = 1;

    // Reset values.
    localparam logic [31:0] STM_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] STM_COUNT_RST = 16'h0001;
    localparam logic [31:0] STM_TIME_RST = 32'h0000_0001;
    localparam logic [31:0] STM_ZERO_RST = 32'h0000_0000;

    // Sequencer resources and bus response codes.
    localparam logic [5:0] STM_LEVELS = 6'h10;
    localparam logic [1:0] STM_RESP_OKAY = 2'h0;
    localparam logic [1:0] STM_RESP_SLVERR = 2'h2;

    // Macro selection codes.
    localparam logic [3:0] MAC_USER = 4'h0;
    localparam logic [3:0] MAC_ANY = 4'h1;
    localparam logic [3:0] MAC_EVENT = 4'h2;
    localparam logic [3:0] MAC_CONSEC = 4'h3;
    localparam logic [3:0] MAC_ADJ = 4'h4;
    localparam logic [3:0] MAC_SEQ = 4'h5;
    localparam logic [3:0] MAC_FEW = 4'h6;
    localparam logic [3:0] MAC_MANY = 4'h7;
    localparam logic [3:0] MAC_SERIAL = 4'h8;
    localparam logic [3:0] MAC_SOON = 4'h9;
    localparam logic [3:0] MAC_LATE = 4'ha;
    localparam logic [3:0] MAC_DELAY = 4'hb;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} stm_state_t;

    // Internal sequence levels a macro occupies.
    function automatic logic [5:0] stm_levels_needed(
        input logic [3:0] mac,
        input logic [4:0] ser_len
    );
        logic [5:0] n;
        n = 6'h01;
        case (mac)
            MAC_ADJ, MAC_SEQ, MAC_MANY, MAC_SOON, MAC_LATE: n = 6'h02;
            MAC_FEW: n = 6'h03;
            MAC_SERIAL: n = {1'b0, ser_len};
            default: n = 6'h01;
        endcase
        return n;
    endfunction

    // Merge a write into a register under byte strobes.
    function automatic logic [31:0] stm_wmerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pattern term with don't-care mask: one bits in msk are compared.
    function automatic logic stm_term_hit(
        input logic [31:0] d,
        input logic [31:0] val,
        input logic [31:0] msk
    );
        return ((d ^ val) & msk) == 32'h0000_0000;
    endfunction

endpackage

// File: core/stm_term_if.sv
`timescale 1ns/100ps
`default_nettype none

interface stm_term_if;
    import stm_pkg::*;
    logic [31:0] data;
    logic [31:0] cmp_ref;
    logic cmp_mode;
    logic [31:0] val [3];
    logic [31:0] msk [3];
    logic [2:0] hit;

    modport seq (output data, cmp_ref, cmp_mode, val, msk, input hit);
    modport match (input data, cmp_ref, cmp_mode, val, msk, output hit);
endinterface

`default_nettype wire

// File: core/stm_term_match.sv
`timescale 1ns/100ps
`default_nettype none

module stm_term_match
    import stm_pkg::*;
(
    stm_term_if.match t
);
    logic [31:0] eff;

    // In compare mode the terms look at the difference from the reference.
    always_comb
    begin
        eff = t.cmp_mode ? (t.data ^ t.cmp_ref) : t.data;
        for (int i = 0; i < 3; i++)
        begin
            t.hit[i] = stm_term_hit(eff, t.val[i], t.msk[i]);
        end
    end
endmodule

`default_nettype wire

// File: verif/stm_sample_src.sv
`timescale 1ns/100ps
`default_nettype none

// Target model: one state per request; between states it shows the inverse.
module stm_sample_src
(
    input wire logic ref_clk,
    input wire logic send,
    input wire logic [31:0] word,
    output logic [31:0] sample_data,
    output logic sample_valid
);
    always_ff @(posedge ref_clk)
    begin
        sample_valid <= send;
        sample_data <= send ? word : ~word;
    end
endmodule

`default_nettype wire

// File: verif/state_trigger_macro_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none

module state_trigger_macro_sequencer_bench;
    import stm_pkg::*;
    typedef struct packed {
        logic [3:0] mac;
        logic cmp;
        logic [7:0] n;
        logic [31:0] seq;
        logic trig;
    } stm_row_t;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic send = 1'b0;
    logic [31:0] word = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] sdat, rdata, rd;
    logic [1:0] bresp, rresp, rr;
    logic sval, awready, wready, bvalid, arready, rvalid, trig_out, irq;
    int errors = 0;
    int comparisons = 0;
    // A nibble of f means no state in that cycle.
    // Pattern one matches odd states, two has bit one set, three is 3.
    stm_row_t rows [20] = '{
        '{MAC_USER, 1'b0, 8'h02, 32'h121fffff, 1'b0},
        '{MAC_USER, 1'b0, 8'h02, 32'h11ffffff, 1'b1},
        '{MAC_ANY, 1'b0, 8'h02, 32'h55ffffff, 1'b1},
        '{MAC_EVENT, 1'b0, 8'h02, 32'h101fffff, 1'b1},
        '{MAC_EVENT, 1'b1, 8'h02, 32'h010fffff, 1'b1},
        '{MAC_CONSEC, 1'b0, 8'h02, 32'h101fffff, 1'b0},
        '{MAC_CONSEC, 1'b0, 8'h02, 32'h011fffff, 1'b1},
        '{MAC_ADJ, 1'b0, 8'h02, 32'h102fffff, 1'b0},
        '{MAC_ADJ, 1'b0, 8'h02, 32'h12ffffff, 1'b1},
        '{MAC_SEQ, 1'b0, 8'h02, 32'h1232ffff, 1'b0},
        '{MAC_SEQ, 1'b0, 8'h02, 32'h0122ffff, 1'b1},
        '{MAC_FEW, 1'b0, 8'h02, 32'h102fffff, 1'b1},
        '{MAC_MANY, 1'b0, 8'h02, 32'h1002ffff, 1'b1},
        '{MAC_SOON, 1'b0, 8'h03, 32'h1ffff2ff, 1'b0},
        '{MAC_DELAY, 1'b0, 8'h03, 32'h00ffffff, 1'b0},
        '{MAC_LATE, 1'b0, 8'h03, 32'h1ffff2ff, 1'b1},
        '{MAC_USER, 1'b0, 8'h02, 32'h13ffffff, 1'b1},
        '{MAC_SEQ, 1'b0, 8'h02, 32'h123fffff, 1'b0},
        '{MAC_SERIAL, 1'b0, 8'h02, 32'h10ffffff, 1'b1},
        '{MAC_SERIAL, 1'b0, 8'h02, 32'h11ffffff, 1'b0}};

    always #25 ref_clk = ~ref_clk;

    stm_sample_src i_src (.ref_clk(ref_clk), .send(send), .word(word),
        .sample_data(sdat), .sample_valid(sval));
    stm_seq_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sample_data(sdat), .sample_valid(sval), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trig_out(trig_out), .irq(irq));

    task automatic print_verdict();
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(inout int t);
        @(posedge ref_clk);
        t++;
        if (t > 200)
        begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            tick(t);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rdreg(input logic [7:0] a);
        int t;
        t = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            tick(t);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    task automatic run(input stm_row_t r);
        logic [3:0] nib;
        wr(STM_REG_COUNT, {24'h0, r.n});
        wr(STM_REG_TIME, {24'h0, r.n});
        wr(STM_REG_CTRL, {24'h0, r.mac, 2'h0, r.cmp, 1'b1});
        for (int i = 7; i >= 0; i--)
        begin
            nib = r.seq[i*4 +: 4];
            @(posedge ref_clk);
            send <= (nib != 4'hf);
            if (nib != 4'hf) word <= {28'h0, nib};
        end
        repeat (3) @(posedge ref_clk);
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdreg(STM_REG_COUNT);
        chk("count", rd, {16'h0, STM_COUNT_RST});
        rdreg(STM_REG_TIME);
        chk("time", rd, STM_TIME_RST);
        rdreg(8'h40);
        chk("unmapped", {rr, rd[29:0]}, {STM_RESP_SLVERR, 30'h0});
        wr(8'h40, 32'h0);
        chk("bresp", {30'h0, bresp}, {30'h0, STM_RESP_SLVERR});
        for (int k = 0; k < 6; k++)
            wr(STM_REG_P1_VAL + 8'(4*k),
                (k == 5) ? 32'hffff_ffff : 32'(k/2+1));
        wr(STM_REG_CMP_REF, 32'h1);
        wr(STM_REG_SERIAL, 32'h0001_0200);
        foreach (rows[i])
        begin
            run(rows[i]);
            chk("trig_out", {31'h0, trig_out}, {31'h0, rows[i].trig});
        end
        rdreg(STM_REG_IRQ_STS);
        chk("irq_sts", rd, 32'h1);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk("trig_out", {31'h0, trig_out}, 32'h0);
        wr(STM_REG_IRQ_MSK, 32'h2);
        wr(STM_REG_SERIAL, 32'h0000_1100);
        wr(STM_REG_CTRL, {24'h0, MAC_SERIAL, 4'h1});
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        rdreg(STM_REG_IRQ_STS);
        chk("irq_sts", rd, 32'h2);
        wr(STM_REG_IRQ_STS, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(STM_REG_IRQ_MSK, 32'h0);
        wr(STM_REG_CTRL, {24'h0, MAC_SERIAL, 4'h1});
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule

`default_nettype wire
